//--- common/dtm_pkg.sv
// Constants, register map and types of the die thermal monitor
package dtm_pkg;
    localparam int NWARN = 6;
    localparam int NCMP = 14;
    localparam int NSTAT = 7;
    localparam int IDX_FALL = 6;
    localparam int IDX_TRIP = 12;
    localparam int IDX_REL = 13;
    localparam int STAT_SD = 6;
    localparam int SENSE_SD = 6;
    localparam int SENSE_PWR = 7;
    localparam int BIT_EN = 0;
    localparam int BIT_AON = 1;
    // Clock rate and timings
    localparam int CLK_MHZ = 100;
    localparam int DB_TIME_US = 10;
    localparam int SMP_WINDOW_US = 450;
    // 3.0 ms interval
    localparam int SMP_INTERVAL_US = 3000;
    // Register map, byte addresses
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CLEAR = 8'h08;
    localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_SENSE = 8'h14;
    localparam logic CTRL_EN_RST = 1'h1;
    localparam logic CTRL_AON_RST = 1'h0;
    localparam logic [NSTAT-1:0] IRQ_EN_RST = 7'h00;
    localparam logic [NWARN-1:0] MASK_RST = 6'h3F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic always_on;
        logic enable;
    } dtm_ctrl_t;
    typedef struct packed {
        logic sd_release;
        logic sd_trip;
        logic [NWARN-1:0] fall;
        logic [NWARN-1:0] rise;
    } dtm_cmp_t;
endpackage

//--- core/dtm_top.sv
// Die thermal monitor: debounce, flags, duty cycle and AXI4-Lite registers
`timescale 1ns/1ps
// Function
// (R1) Interrupts and shutdown come only from the die-centre sensor.
// (R2) Six warning levels, each with latched irq, live sense and mask bits.
// (R3) A warning level being crossed sets its irq bit.
// (R4) A sense bit clears only once the temperature is 5 C below its level.
// (R5) Shutdown trips at its level and holds until its hysteresis is passed.
// (R6) Every comparator is debounced 10 us in both directions.
// (R7) The enable bit written by the host turns the monitor on or off.
// (R8) In run, always-on keeps the monitor powered, else it samples.
// (R9) Sampling powers the monitor 450 us in every 3.0 ms.
// (R10) In standby the monitor only samples while enabled.
// (R11) A set irq bit drives the low-active pin only when unmasked.
// (R12) Irq bits stay until cleared; sense bits follow the comparators.
module dtm_top
    import dtm_pkg::*;
#(
    parameter int WINDOW_CYC = SMP_WINDOW_US * CLK_MHZ,
    parameter int INTERVAL_CYC = SMP_INTERVAL_US * CLK_MHZ,
    parameter int DEBOUNCE_CYC = DB_TIME_US * CLK_MHZ
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Centre sensor comparators and power state
    input wire dtm_cmp_t cmp_in,
    input wire logic standby,
    // Monitor outputs
    output logic monitor_power,
    output logic thermal_shutdown,
    output logic irq_out_n,
    output logic irq
);
    localparam int SMP_W = $clog2(INTERVAL_CYC + 1);
    localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
    if (WINDOW_CYC < 1 || WINDOW_CYC >= INTERVAL_CYC || DEBOUNCE_CYC < 2)
    begin : g_bad_param
        $error("dtm_top: window, interval or debounce count unusable");
    end
    dtm_ctrl_t ctrl;
    logic [NSTAT-1:0] status;
    logic [NSTAT-1:0] irq_en;
    logic [NWARN-1:0] mask;
    logic [NWARN-1:0] warn_sense;
    logic [NWARN-1:0] next_sense;
    logic [NSTAT-1:0] set_bits;
    logic [NSTAT-1:0] clr_bits;
    logic [NCMP-1:0] cmp_s1;
    logic [NCMP-1:0] cmp_s2;
    logic [NCMP-1:0] db_state;
    logic [DB_W-1:0] db_cnt [NCMP];
    logic [SMP_W-1:0] smp_cnt;
    logic in_window;
    logic next_power;
    logic next_sd;
    logic aw_hold;
    logic w_hold;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_strb0_q;
    logic do_wr;
    logic wr_ok;
    // Register read decode
    function automatic logic [32:0] rd_word(input logic [AXI_AW-1:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case ({a[AXI_AW-1:2], 2'b00})
            OFF_CTRL: r = {1'b1, 30'h0, ctrl};
            OFF_STATUS: r = {1'b1, 25'h0, status};
            OFF_CLEAR: r = {1'b1, 32'h0000_0000};
            OFF_IRQ_EN: r = {1'b1, 25'h0, irq_en};
            OFF_MASK: r = {1'b1, 26'h0, mask};
            OFF_SENSE: r = {1'b1, 24'h0, monitor_power, thermal_shutdown,
                            warn_sense};
            default: r = {1'b0, 32'h0000_0000};
        endcase
        return r;
    endfunction

    // Sampling duty cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl.enable) begin
            smp_cnt <= '0;
        end else if (smp_cnt == SMP_W'(INTERVAL_CYC - 1)) begin
            smp_cnt <= '0; // [R9]
        end else begin
            smp_cnt <= smp_cnt + SMP_W'(1);
        end
    end

    always_comb begin
        in_window = smp_cnt < SMP_W'(WINDOW_CYC); // [R9]
        next_power = ctrl.enable // [R7]
            && ((ctrl.always_on && !standby) || in_window); // [R8] [R10]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            monitor_power <= 1'b0;
        end else begin
            monitor_power <= next_power;
        end
    end

    // Comparator synchroniser, centre sensor only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_s1 <= '0;
            cmp_s2 <= '0;
        end else begin
            cmp_s1 <= cmp_in; // [R1]
            cmp_s2 <= cmp_s1;
        end
    end

    // Debounce, counts cleared while the monitor is unpowered, state cleared too while disabled
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl.enable) begin
            db_state <= '0;
            for (int i = 0; i < NCMP; i++) begin
                db_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCMP; i++) begin
                if (!monitor_power || cmp_s2[i] == db_state[i]) begin
                    db_cnt[i] <= '0;
                end else if (db_cnt[i] == DB_W'(DEBOUNCE_CYC - 1)) begin
                    db_state[i] <= cmp_s2[i]; // [R6]
                    db_cnt[i] <= '0;
                end else begin
                    db_cnt[i] <= db_cnt[i] + DB_W'(1); // [R6]
                end
            end
        end
    end

    // Sense with hysteresis and shutdown latch
    always_comb begin
        for (int i = 0; i < NWARN; i++) begin
            if (db_state[i]) begin
                next_sense[i] = 1'b1; // [R2]
            end else if (!db_state[IDX_FALL + i]) begin
                next_sense[i] = 1'b0; // [R4]
            end else begin
                next_sense[i] = warn_sense[i];
            end
        end
        if (db_state[IDX_TRIP]) begin
            next_sd = 1'b1; // [R5]
        end else if (!db_state[IDX_REL]) begin
            next_sd = 1'b0; // [R5]
        end else begin
            next_sd = thermal_shutdown;
        end
        set_bits = {next_sd & ~thermal_shutdown,
                    next_sense & ~warn_sense}; // [R3]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warn_sense <= '0;
            thermal_shutdown <= 1'b0;
        end else begin
            warn_sense <= next_sense; // [R12]
            thermal_shutdown <= next_sd;
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
        end else begin
            status <= (status & ~clr_bits) | set_bits; // [R12] [R3]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_out_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            irq_out_n <= ~|(status[NWARN-1:0] & ~mask); // [R11]
            irq <= |(status & irq_en);
        end
    end

    // AXI4-Lite write path
    always_comb begin
        do_wr = aw_hold && w_hold && !bvalid;
        wr_ok = rd_word(aw_addr_q) >> 32 == 33'h1;
        clr_bits = '0;
        if (do_wr && w_strb0_q && {aw_addr_q[AXI_AW-1:2], 2'b00} == OFF_CLEAR)
        begin
            clr_bits = w_data_q[NSTAT-1:0]; // [R12]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb0_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_hold <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (!aw_hold && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_hold <= 1'b1;
                w_data_q <= wdata;
                w_strb0_q <= wstrb[0];
            end else if (!w_hold && !bvalid) begin
                wready <= 1'b1;
            end
            if (do_wr) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl.enable <= CTRL_EN_RST;
            ctrl.always_on <= CTRL_AON_RST;
            irq_en <= IRQ_EN_RST;
            mask <= MASK_RST;
        end else if (do_wr && w_strb0_q) begin
            case ({aw_addr_q[AXI_AW-1:2], 2'b00})
                OFF_CTRL: begin
                    ctrl.enable <= w_data_q[BIT_EN]; // [R7]
                    ctrl.always_on <= w_data_q[BIT_AON]; // [R8]
                end
                OFF_IRQ_EN: irq_en <= w_data_q[NSTAT-1:0];
                OFF_MASK: mask <= w_data_q[NWARN-1:0]; // [R11]
                default: ;
            endcase
        end
    end

    // AXI4-Lite read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= 32'(rd_word(araddr));
            rresp <= rd_word(araddr) >> 32 == 33'h1 ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_sense_hyst: assert property ( // [R4]
        (($past(warn_sense) & ~warn_sense & $past(db_state[IDX_FALL+:NWARN]))
         == '0))
        else $error("sense released above hysteresis level");
    a_irq_on_cross: assert property ( // [R3]
        ((warn_sense & ~$past(warn_sense) & ~status[NWARN-1:0]) == '0))
        else $error("crossing did not set irq bit");
    a_irq_latched: assert property ( // [R12]
        (($past(status) & ~status & ~$past(clr_bits)) == '0))
        else $error("irq bit dropped without clear");
    a_pin_masked: assert property ( // [R11]
        ##1 irq_out_n == !(|($past(status[NWARN-1:0]) & ~$past(mask))))
        else $error("interrupt pin disagrees with irq and mask");
    a_debounce_len: assert property ( // [R6]
        ctrl.enable && $past(ctrl.enable) && $changed(db_state[0])
        |-> $past(db_cnt[0]) == DB_W'(DEBOUNCE_CYC - 1))
        else $error("comparator change before debounce time");
    a_sd_trip: assert property ( // [R5]
        $rose(db_state[IDX_TRIP]) |=> thermal_shutdown)
        else $error("shutdown not entered");
    a_sd_hold: assert property ( // [R5]
        thermal_shutdown && db_state[IDX_REL] |=> thermal_shutdown)
        else $error("shutdown left before hysteresis");
    a_mon_off: assert property ( // [R7]
        !ctrl.enable |=> !monitor_power)
        else $error("monitor powered while disabled");
    a_always_on: assert property ( // [R8]
        ctrl.enable && ctrl.always_on && !standby |=> monitor_power)
        else $error("always-on monitor unpowered");
    a_sample_win: assert property ( // [R9] [R10]
        ctrl.enable && (standby || !ctrl.always_on)
        |=> monitor_power == ($past(smp_cnt) < SMP_W'(WINDOW_CYC)))
        else $error("sampling window wrong");

    c_irq_set: cover property ($rose(status[0]));
    c_shutdown: cover property ($rose(thermal_shutdown));
    c_window: cover property ($fell(monitor_power) && !ctrl.always_on);
    c_clear: cover property (|clr_bits);
endmodule

//--- dv/dtm_sensor.sv
// Comparator model of the die-centre temperature sensor
`timescale 1ns/1ps
module dtm_sensor
    import dtm_pkg::*;
#(
    parameter int SD_LEVEL = 165,
    parameter int SD_HYS = 10
) (
    // Die-centre temperature in degrees C, the only source used
    input var int temp_c,
    // Comparator levels, high when above
    output dtm_cmp_t cmp
);
    always_comb begin
        for (int i = 0; i < NWARN; i++) begin
            cmp.rise[i] = temp_c > 80 + 15 * i;
            cmp.fall[i] = temp_c > 75 + 15 * i;
        end
        cmp.sd_trip = temp_c > SD_LEVEL;
        cmp.sd_release = temp_c > SD_LEVEL - SD_HYS;
    end
endmodule

//--- dv/tb.sv
// Self-checking bench of the die thermal monitor
`timescale 1ns/1ps
module tb;
    import dtm_pkg::*;
    localparam int PER = 100;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic standby = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic monitor_power, thermal_shutdown, irq_out_n, irq;
    dtm_cmp_t cmp_in;
    int temp_c = 25;
    int n_fail = 0;
    int tests_run = 0;
    logic [33:0] exp_q[$];
    logic [5:0] m;

    always #5 aclk = ~aclk;

    dtm_sensor u_sens (.temp_c(temp_c), .cmp(cmp_in));
    dtm_top #(.WINDOW_CYC(20), .INTERVAL_CYC(PER), .DEBOUNCE_CYC(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cmp_in(cmp_in), .standby(standby), .monitor_power(monitor_power),
        .thermal_shutdown(thermal_shutdown), .irq_out_n(irq_out_n), .irq(irq)
    );

    task automatic chk_bus(input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t bus got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t pin got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run();
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Response watcher
    always @(posedge aclk) begin
        if (bvalid && bready)
            chk_bus(exp_q.pop_front(), {bresp, 32'h0});
        if (rvalid && rready)
            chk_bus(exp_q.pop_front(), {rresp, rdata});
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        bit aw = 0;
        bit w = 0;
        @(posedge aclk);
        exp_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            aw |= awready;
            w |= wready;
            awvalid <= !aw;
            wvalid <= !w;
        end while (!(aw && w));
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        exp_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
    endtask

    // Counts powered cycles over one sampling interval
    task automatic cnt(input logic [31:0] e);
        logic [31:0] s;
        s = 32'h0;
        repeat (4) @(posedge aclk);
        repeat (PER) begin
            @(posedge aclk);
            s += monitor_power;
        end
        chk_val(e, s);
    endtask

    initial begin
        #100000;
        n_fail++;
        complete_run();
    end

    initial begin
        void'($urandom(32'hb8e55ac8));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(OFF_CTRL, 32'h1);
        rd(OFF_MASK, 32'h3F);
        rd(OFF_IRQ_EN, 32'h0);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(OFF_CTRL, 32'h3);
        repeat (3) @(posedge aclk);
        temp_c <= 100;
        repeat (2) @(posedge aclk);
        temp_c <= 60;
        repeat (15) @(posedge aclk);
        rd(OFF_SENSE, 32'h80);
        rd(OFF_STATUS, 32'h0);
        temp_c <= 100;
        repeat (15) @(posedge aclk);
        rd(OFF_SENSE, 32'h83);
        rd(OFF_STATUS, 32'h3);
        chk_val(32'h1, irq_out_n);
        m = 6'($urandom_range(0, 63));
        wr(OFF_MASK, {26'h0, m});
        repeat (3) @(posedge aclk);
        rd(OFF_MASK, {26'h0, m});
        chk_val(~|(2'h3 & ~m[1:0]), irq_out_n);
        wstrb <= 4'hE;
        wr(OFF_MASK, 32'h0);
        wstrb <= 4'hF;
        rd(OFF_MASK, {26'h0, m});
        wr(8'h40, 32'h0, RESP_SLVERR);
        wr(OFF_SENSE, 32'h0);
        wr(OFF_STATUS, 32'h0);
        rd(OFF_SENSE, 32'h83);
        rd(OFF_STATUS, 32'h3);
        wr(OFF_MASK, 32'h3E);
        wr(OFF_IRQ_EN, 32'h1);
        repeat (3) @(posedge aclk);
        chk_val(32'h0, irq_out_n);
        chk_val(32'h1, irq);
        temp_c <= 92;
        repeat (15) @(posedge aclk);
        rd(OFF_SENSE, 32'h83);
        temp_c <= 89;
        repeat (15) @(posedge aclk);
        rd(OFF_SENSE, 32'h81);
        rd(OFF_STATUS, 32'h3);
        wr(OFF_CLEAR, 32'h1);
        repeat (3) @(posedge aclk);
        rd(OFF_STATUS, 32'h2);
        chk_val(32'h1, irq_out_n);
        chk_val(32'h0, irq);
        temp_c <= 170;
        repeat (15) @(posedge aclk);
        chk_val(32'h1, thermal_shutdown);
        rd(OFF_STATUS, 32'h7E);
        rd(OFF_SENSE, 32'hFF);
        temp_c <= 160;
        repeat (15) @(posedge aclk);
        chk_val(32'h1, thermal_shutdown);
        temp_c <= 150;
        repeat (15) @(posedge aclk);
        chk_val(32'h0, thermal_shutdown);
        rd(OFF_SENSE, 32'h9F);
        wr(OFF_CTRL, 32'h1);
        cnt(32'd20);
        standby <= 1'h1;
        wr(OFF_CTRL, 32'h3);
        cnt(32'd20);
        standby <= 1'h0;
        cnt(32'd100);
        wr(OFF_CTRL, 32'h0);
        cnt(32'd0);
        rd(OFF_SENSE, 32'h0);
        complete_run();
    end
endmodule
